// ---- rtl/ccc_pkg.sv ----
package ccc_pkg;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [7:0] ADDR_FUNC      = 8'h03;
    localparam logic [7:0] ADDR_IFACE     = 8'h04;
    localparam logic [7:0] ADDR_MISC      = 8'h05;
    localparam logic [7:0] ADDR_CLK       = 8'h06;
    localparam logic [7:0] ADDR_RATIO     = 8'h07;
    localparam logic [7:0] ADDR_STATUS    = 8'h08;
    localparam logic [7:0] ADDR_FRZ_FIRST = 8'h0f;
    localparam logic [7:0] ADDR_FRZ_LAST  = 8'h1b;
    localparam int         FRZ_COUNT      = 13;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int MISC_EXT_SCLK = 7;
    localparam int MISC_HIZ      = 6;
    localparam int MISC_FREEZE   = 4;
    localparam int MISC_FILT     = 3;
    localparam int MISC_HPF      = 2;
    localparam int MISC_PLAY_MS  = 1;
    localparam int MISC_CAP_MS   = 0;
    localparam int CLK_DIV_LSB   = 6;
    localparam int CLK_FREQ_LSB  = 4;
    localparam int CLK_TRACK     = 3;
    localparam int CLK_SW_LSB    = 1;
    localparam int CLK_FORCE     = 0;
    localparam int IFACE_RJ16    = 0;
    localparam int FUNC_CAPCLK   = 2;
    localparam int STAT_ACTIVE   = 3;

    localparam logic [7:0] MISC_MASK  = 8'hdf;
    localparam logic [7:0] MISC_RST   = 8'h00;
    localparam logic [7:0] CLK_RST    = 8'h00;
    localparam logic [7:0] RATIO_RST  = 8'h00;
    localparam logic [7:0] FRZ_RST    = 8'h00;

    // ************************************************************
    // Codes and counts
    // ************************************************************
    localparam logic [1:0] DIV_BY1   = 2'b00;
    localparam logic [1:0] DIV_BY2   = 2'b01;
    localparam logic [1:0] DIV_BY4   = 2'b10;
    localparam logic [1:0] DIV_MUL2  = 2'b11;
    localparam logic [1:0] SW_PLL    = 2'b00;
    localparam logic [1:0] SW_OSC    = 2'b01;
    localparam logic [1:0] SW_HOLD   = 2'b10;
    localparam logic [1:0] SW_AUTO   = 2'b11;
    localparam logic [1:0] FREQ_RSVD = 2'b11;
    localparam logic [2:0] PLL_CODE_FORCED = 3'b111;
    localparam logic [6:0] RATIO_WINDOW    = 7'h40;
    localparam logic [7:0] RATIO_MAX       = 8'hff;
    localparam logic [3:0] BCLK_HALF       = 4'h2;
    localparam logic [5:0] LRCK_HALF       = 6'h20;

    typedef enum logic [1:0] {
        SRC_PLL = 2'b01,
        SRC_OSC = 2'b10
    } ccc_src_t;

endpackage

// ---- rtl/ccc_clk_if.sv ----
`timescale 1ns/10ps
interface ccc_clk_if;
    logic [1:0] swSel;
    logic       forced;
    logic       pllUnlock;
    logic       pllLvl;
    logic       oscLvl;
    logic [1:0] divSel;
    logic       activeOsc;
    logic       mclkLvl;
    logic       mclkRise;
    logic       rmckLvl;

    modport ctrl (
        output swSel, forced, pllUnlock, pllLvl, oscLvl, divSel,
        input  activeOsc, mclkLvl, mclkRise, rmckLvl
    );
    modport sel (
        input  swSel, forced, pllUnlock, pllLvl, oscLvl, divSel,
        output activeOsc, mclkLvl, mclkRise, rmckLvl
    );
endinterface

// ---- rtl/ccc_clk_sel.sv ----
`timescale 1ns/10ps
module ccc_clk_sel
    import ccc_pkg::*;
(
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic clkEn,
    // Control side
    ccc_clk_if.sel    bus
);

    // ************************************************************
    // Source selection
    // ************************************************************
    ccc_src_t   state_q;
    ccc_src_t   state_d;
    logic       mclkPrev_q;
    logic       basePrev_q;
    logic [1:0] divCnt_q;
    logic       recovered_clock_out_q;

    // R15 source select table
    always_comb begin
        state_d = state_q;
        unique case (bus.swSel)
            SW_PLL:  state_d = SRC_PLL;
            SW_OSC:  state_d = SRC_OSC;
            SW_HOLD: state_d = bus.pllUnlock ? SRC_OSC : state_q;
            SW_AUTO: state_d = bus.pllUnlock ? SRC_OSC : SRC_PLL;
        endcase
    end

    wire logic activeOsc = (state_q == SRC_OSC);
    wire logic mclkLvl   = activeOsc ? bus.oscLvl : bus.pllLvl;
    // R16 fallback of recovered clock; R18 none under forced lock
    wire logic rmckOsc   = activeOsc | ((bus.swSel == SW_PLL)
                           & bus.pllUnlock & ~bus.forced);
    wire logic baseLvl   = rmckOsc ? bus.oscLvl : bus.pllLvl;
    wire logic baseRise  = baseLvl & ~basePrev_q;
    wire logic baseEdge  = baseLvl ^ basePrev_q;

    // R12 recovered clock scaling
    logic recovered_clock_out_d;
    always_comb begin
        recovered_clock_out_d = recovered_clock_out_q;
        unique case (bus.divSel)
            DIV_BY1:  recovered_clock_out_d = baseLvl;
            DIV_BY2:  recovered_clock_out_d = baseRise ? ~recovered_clock_out_q : recovered_clock_out_q;
            DIV_BY4:  recovered_clock_out_d = (baseRise & divCnt_q[0]) ? ~recovered_clock_out_q : recovered_clock_out_q;
            DIV_MUL2: recovered_clock_out_d = baseEdge ? ~recovered_clock_out_q : recovered_clock_out_q;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_q    <= SRC_PLL;
            mclkPrev_q <= 1'b0;
            basePrev_q <= 1'b0;
            divCnt_q   <= 2'b00;
            recovered_clock_out_q     <= 1'b0;
        end else if (clkEn) begin
            state_q    <= state_d;
            mclkPrev_q <= mclkLvl;
            basePrev_q <= baseLvl;
            divCnt_q   <= baseRise ? divCnt_q + 2'b01 : divCnt_q;
            recovered_clock_out_q     <= recovered_clock_out_d;
        end
    end

    assign bus.activeOsc = activeOsc;
    assign bus.mclkLvl   = mclkLvl;
    assign bus.mclkRise  = mclkLvl & ~mclkPrev_q;
    assign bus.rmckLvl   = recovered_clock_out_q;

endmodule

// ---- rtl/ccc_top.sv ----
// What this block does
// R1: Word-length bit picks 24 or 16 bit.
// R2: External converter bit clock source select.
// R3: Tri-state bit floats recovered clock output.
// R4: Freeze holds gain changes, applies together.
// R5: Filter bit selects fast or slow rolloff.
// R6: Highpass hold freezes offset estimate.
// R7: Playback port master drives divided clocks.
// R8: Partner supplies playback frame clock in slave.
// R9: Capture port master drives divided clocks.
// R10: Partner supplies capture frame clock in slave.
// R11: Frame tracking needs capture port slave.
// R12: Divider scales recovered clock by code.
// R13: Software sets reference frequency code correctly.
// R14: PLL tracks capture frame clock when enabled.
// R15: Source select: PLL, oscillator, hold, auto.
// R16: Unlocked at code 00: recovered clock oscillator.
// R17: Software keeps source code 00 under force.
// R18: Forced lock: no oscillator fallback on unlock.
// R19: Forced lock: no autodetect, ratio invalid, 111.
// R20: Software picks de-emphasis rate under force.
// R21: Ratio register reports oscillator/PLL in 2.6.
// R22: Capture data clocked by chosen port.
// R23: Status bit shows active master clock source.
// R24: Reserved bits read zero, no effect.
`timescale 1ns/10ps
module ccc_top
    import ccc_pkg::*;
(
    // Clock and reset
    input  wire logic                   core_clk,
    input  wire logic                   rst,
    input  wire logic                   clkEn,
    // Control port
    input  wire logic [7:0]             regAddr,
    input  wire logic [7:0]             regWrData,
    input  wire logic                   regWrEn,
    input  wire logic                   regRdEn,
    output logic      [7:0]             regRdData,
    output logic                        regRdValid,
    // Clock sources and PLL status
    input  wire logic                   pllClkIn,
    input  wire logic                   oscClkIn,
    input  wire logic                   pllUnlock,
    input  wire logic [2:0]             pllFreqCode,
    // Playback serial port pins
    input  wire logic                   playBitClkIn,
    output logic                        playBitClkOut,
    output logic                        playBitClkOe,
    input  wire logic                   playFrameIn,
    output logic                        playFrameOut,
    output logic                        playFrameOe,
    // Capture serial port pins
    input  wire logic                   capBitClkIn,
    output logic                        capBitClkOut,
    output logic                        capBitClkOe,
    input  wire logic                   capFrameIn,
    output logic                        capFrameOut,
    output logic                        capFrameOe,
    // Derived clocks
    output logic                        extConvBitClk,
    output logic                        capDataBitClk,
    output logic                        capDataFrame,
    output logic                        rmckOut,
    output logic                        rmckOe,
    output logic                        pllRefTrack,
    output logic                        pllRefClk,
    // Datapath controls
    output logic                        rjWordLen16,
    output logic                        interpRolloffSlow,
    output logic                        highpassHold,
    output logic                        rateAutoDetectEn,
    output logic [FRZ_COUNT*8-1:0]      gainActive
);

    // ************************************************************
    // Register file
    // ************************************************************
    logic [7:0] miscCtrl_q;
    logic [7:0] clockCtrl_q;
    logic       rj16_q;
    logic       capClkSel_q;
    logic [7:0] ratio_q;
    logic [7:0] frzShadow_q [FRZ_COUNT];

    wire logic       freeze     = miscCtrl_q[MISC_FREEZE];
    wire logic       playMaster = miscCtrl_q[MISC_PLAY_MS];
    wire logic       capMaster  = miscCtrl_q[MISC_CAP_MS];
    wire logic       forced     = clockCtrl_q[CLK_FORCE];
    wire logic [1:0] swSel      = clockCtrl_q[CLK_SW_LSB +: 2];
    wire logic       inFrzRange = (regAddr >= ADDR_FRZ_FIRST)
                                  && (regAddr <= ADDR_FRZ_LAST);
    wire logic [7:0] frzIndex   = regAddr - ADDR_FRZ_FIRST;
    wire logic       wrMisc     = regWrEn && (regAddr == ADDR_MISC);
    wire logic       wrClk      = regWrEn && (regAddr == ADDR_CLK);

    // R24 reserved frequency code stored as zero
    wire logic [7:0] clkWrVal =
        (regWrData[CLK_FREQ_LSB +: 2] == FREQ_RSVD)
        ? (regWrData & ~(8'h03 << CLK_FREQ_LSB)) : regWrData;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            miscCtrl_q  <= MISC_RST;
            clockCtrl_q <= CLK_RST;
            rj16_q      <= 1'b0;
            capClkSel_q <= 1'b0;
        end else if (clkEn && regWrEn) begin
            // R24 reserved bits dropped
            if (wrMisc) begin
                miscCtrl_q <= regWrData & MISC_MASK;
            end
            if (wrClk) begin
                clockCtrl_q <= clkWrVal;
            end
            if (regAddr == ADDR_IFACE) begin
                rj16_q <= regWrData[IFACE_RJ16];
            end
            if (regAddr == ADDR_FUNC) begin
                capClkSel_q <= regWrData[FUNC_CAPCLK];
            end
        end
    end

    // ************************************************************
    // Freezable gain registers
    // ************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < FRZ_COUNT; gi++) begin : g_frz
            always_ff @(posedge core_clk) begin
                if (rst) begin
                    frzShadow_q[gi] <= FRZ_RST;
                end else if (clkEn && regWrEn && inFrzRange
                             && frzIndex == 8'(gi)) begin
                    frzShadow_q[gi] <= regWrData;
                end
            end
            // R4 stored value reaches outputs only unfrozen
            always_ff @(posedge core_clk) begin
                if (rst) begin
                    gainActive[gi*8 +: 8] <= FRZ_RST;
                end else if (clkEn && !freeze) begin
                    gainActive[gi*8 +: 8] <= frzShadow_q[gi];
                end
            end
        end
    endgenerate

    // ************************************************************
    // Clock source selection
    // ************************************************************
    ccc_clk_if clkBus ();

    assign clkBus.swSel     = swSel;
    assign clkBus.forced    = forced;
    assign clkBus.pllUnlock = pllUnlock;
    assign clkBus.pllLvl    = pllClkIn;
    assign clkBus.oscLvl    = oscClkIn;
    assign clkBus.divSel    = clockCtrl_q[CLK_DIV_LSB +: 2];

    ccc_clk_sel u_sel (
        .core_clk (core_clk),
        .rst      (rst),
        .clkEn    (clkEn),
        .bus      (clkBus.sel)
    );

    // ************************************************************
    // Master serial clock dividers
    // ************************************************************
    logic [3:0] bclkCnt_q;
    logic [5:0] lrckCnt_q;
    logic       genBclk_q;
    logic       genLrck_q;

    wire logic bclkTick = clkBus.mclkRise && (bclkCnt_q == BCLK_HALF - 4'h1);
    wire logic lrckTick = bclkTick && genBclk_q
                          && (lrckCnt_q == LRCK_HALF - 6'h01);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            bclkCnt_q <= 4'h0;
            lrckCnt_q <= 6'h00;
            genBclk_q <= 1'b0;
            genLrck_q <= 1'b0;
        end else if (clkEn && clkBus.mclkRise) begin
            bclkCnt_q <= bclkTick ? 4'h0 : bclkCnt_q + 4'h1;
            genBclk_q <= bclkTick ? ~genBclk_q : genBclk_q;
            if (bclkTick && genBclk_q) begin
                lrckCnt_q <= lrckTick ? 6'h00 : lrckCnt_q + 6'h01;
            end
            genLrck_q <= lrckTick ? ~genLrck_q : genLrck_q;
        end
    end

    // R7 playback master drives, slave takes pins (R8 partner frame)
    wire logic playBclk  = playMaster ? genBclk_q : playBitClkIn;
    wire logic playFrame = playMaster ? genLrck_q : playFrameIn;
    // R9 capture master drives, slave takes pins (R10 partner frame)
    wire logic capBclk   = capMaster ? genBclk_q : capBitClkIn;
    wire logic capFrame  = capMaster ? genLrck_q : capFrameIn;
    // R11 R14 tracking only with capture port slave
    wire logic track     = clockCtrl_q[CLK_TRACK] && !capMaster;

    // ************************************************************
    // Ratio measurement
    // ************************************************************
    logic       pllPrev_q;
    logic       oscPrev_q;
    logic [6:0] winCnt_q;
    logic [7:0] oscCnt_q;

    wire logic pllRise = pllClkIn && !pllPrev_q;
    wire logic oscRise = oscClkIn && !oscPrev_q;
    wire logic winEnd  = pllRise && (winCnt_q == RATIO_WINDOW - 7'h01);
    wire logic oscSat  = (oscCnt_q == RATIO_MAX);
    wire logic [7:0] oscNext = (oscRise && !oscSat) ? oscCnt_q + 8'h01
                                                     : oscCnt_q;

    // R21 osc edges per 64 PLL edges is 2.6 fixed point
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pllPrev_q <= 1'b0;
            oscPrev_q <= 1'b0;
            winCnt_q  <= 7'h00;
            oscCnt_q  <= 8'h00;
            ratio_q   <= RATIO_RST;
        end else if (clkEn) begin
            pllPrev_q <= pllClkIn;
            oscPrev_q <= oscClkIn;
            winCnt_q  <= winEnd ? 7'h00 : winCnt_q + {6'h00, pllRise};
            oscCnt_q  <= winEnd ? 8'h00 : oscNext;
            if (winEnd) begin
                ratio_q <= oscNext;
            end
        end
    end

    // ************************************************************
    // Read path
    // ************************************************************
    // R19 forced lock forces code 111; R23 active source bit
    wire logic [2:0] freqCode = forced ? PLL_CODE_FORCED : pllFreqCode;
    wire logic [7:0] statusVal = {4'h0, clkBus.activeOsc, freqCode};
    logic [7:0] rdMux;
    always_comb begin
        rdMux = 8'h00;
        if (inFrzRange) begin
            rdMux = frzShadow_q[frzIndex[3:0]];
        end else begin
            unique case (regAddr)
                ADDR_FUNC:   rdMux = {5'h00, capClkSel_q, 2'b00};
                ADDR_IFACE:  rdMux = {7'h00, rj16_q};
                ADDR_MISC:   rdMux = miscCtrl_q;
                ADDR_CLK:    rdMux = clockCtrl_q;
                ADDR_RATIO:  rdMux = ratio_q;
                ADDR_STATUS: rdMux = statusVal;
                default:     rdMux = 8'h00;
            endcase
        end
    end

    // ************************************************************
    // Output registers
    // ************************************************************
    always_ff @(posedge core_clk) begin
        if (rst) begin
            regRdData         <= 8'h00;
            regRdValid        <= 1'b0;
            playBitClkOut     <= 1'b0;
            playBitClkOe      <= 1'b0;
            playFrameOut      <= 1'b0;
            playFrameOe       <= 1'b0;
            capBitClkOut      <= 1'b0;
            capBitClkOe       <= 1'b0;
            capFrameOut       <= 1'b0;
            capFrameOe        <= 1'b0;
            extConvBitClk     <= 1'b0;
            capDataBitClk     <= 1'b0;
            capDataFrame      <= 1'b0;
            rmckOut           <= 1'b0;
            rmckOe            <= 1'b1;
            pllRefTrack       <= 1'b0;
            pllRefClk         <= 1'b0;
            rjWordLen16       <= 1'b0;
            interpRolloffSlow <= 1'b0;
            highpassHold      <= 1'b0;
            rateAutoDetectEn  <= 1'b1;
        end else if (clkEn) begin
            regRdData         <= regRdEn ? rdMux : regRdData;
            regRdValid        <= regRdEn;
            playBitClkOut     <= genBclk_q;
            playBitClkOe      <= playMaster;
            playFrameOut      <= genLrck_q;
            playFrameOe       <= playMaster;
            capBitClkOut      <= genBclk_q;
            capBitClkOe       <= capMaster;
            capFrameOut       <= genLrck_q;
            capFrameOe        <= capMaster;
            // R2 external converter bit clock
            extConvBitClk     <= miscCtrl_q[MISC_EXT_SCLK] ? playBclk
                                                            : capBclk;
            // R22 capture data clock port
            capDataBitClk     <= capClkSel_q ? capBclk : playBclk;
            capDataFrame      <= capClkSel_q ? capFrame : playFrame;
            rmckOut           <= clkBus.rmckLvl;
            // R3 recovered clock tri-state
            rmckOe            <= !miscCtrl_q[MISC_HIZ];
            // R14 PLL reference from capture frame
            pllRefTrack       <= track;
            pllRefClk         <= track ? capFrame : 1'b0;
            // R1 word length
            rjWordLen16       <= rj16_q;
            // R5 rolloff select
            interpRolloffSlow <= miscCtrl_q[MISC_FILT];
            // R6 highpass hold
            highpassHold      <= miscCtrl_q[MISC_HPF];
            // R19 autodetect off when forced
            rateAutoDetectEn  <= !forced;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    property p_wordlen;
        @(posedge core_clk) disable iff (rst)
        clkEn ##1 clkEn |-> rjWordLen16 == $past(rj16_q);
    endproperty
    a_wordlen: assert property (p_wordlen) // R1
        else $error("word length output mismatch");

    property p_hiz;
        @(posedge core_clk) disable iff (rst)
        wrMisc && clkEn ##1 clkEn |=> rmckOe == !$past(regWrData[MISC_HIZ], 2);
    endproperty
    a_hiz: assert property (p_hiz) // R3
        else $error("recovered clock enable wrong after write");

    property p_freeze;
        @(posedge core_clk) disable iff (rst)
        freeze ##1 freeze |-> $stable(gainActive);
    endproperty
    a_freeze: assert property (p_freeze) // R4
        else $error("gain output moved while frozen");

    property p_playoe;
        @(posedge core_clk) disable iff (rst)
        clkEn ##1 clkEn |-> playBitClkOe == $past(playMaster)
                            && playFrameOe == $past(playMaster);
    endproperty
    a_playoe: assert property (p_playoe) // R7
        else $error("playback pin direction wrong");

    property p_capoe;
        @(posedge core_clk) disable iff (rst)
        clkEn ##1 clkEn |-> capFrameOe == $past(capMaster);
    endproperty
    a_capoe: assert property (p_capoe) // R9
        else $error("capture pin direction wrong");

    property p_track;
        @(posedge core_clk) disable iff (rst)
        pllRefTrack |-> !capFrameOe;
    endproperty
    a_track: assert property (p_track) // R11
        else $error("tracking with capture port master");

    property p_manual;
        @(posedge core_clk) disable iff (rst)
        clkEn && swSel == SW_OSC |=> clkBus.activeOsc;
    endproperty
    a_manual: assert property (p_manual) // R15
        else $error("manual oscillator select not applied");

    property p_autofall;
        @(posedge core_clk) disable iff (rst)
        clkEn && swSel[1] && pllUnlock |=> clkBus.activeOsc;
    endproperty
    a_autofall: assert property (p_autofall) // R15
        else $error("no oscillator fallback on unlock");

    property p_forced;
        @(posedge core_clk) disable iff (rst)
        forced && regRdEn && regAddr == ADDR_STATUS && clkEn
        |=> regRdData[2:0] == PLL_CODE_FORCED;
    endproperty
    a_forced: assert property (p_forced) // R19
        else $error("forced lock frequency code not 111");

    property p_reserved;
        @(posedge core_clk) disable iff (rst)
        regRdEn && clkEn && regAddr == ADDR_MISC |=> !regRdData[5];
    endproperty
    a_reserved: assert property (p_reserved) // R24
        else $error("reserved bit read as one");

endmodule

// ---- tb/ccc_far_end.sv ----
`timescale 1ns/10ps
module ccc_far_end (
    // Clock in
    input  wire logic core_clk,
    // Clocks supplied by the far side
    output logic      pllClk,
    output logic      oscClk,
    output logic      bitClk,
    output logic      frameClk
);
    logic [7:0] cnt = 8'h00;

    always @(negedge core_clk) begin
        cnt <= cnt + 8'h01;
    end

    // Oscillator runs at twice the PLL rate, so the ratio reads 2.0.
    assign oscClk   = cnt[0];
    assign pllClk   = cnt[1];
    assign bitClk   = cnt[1];
    assign frameClk = cnt[6];
endmodule

// ---- tb/codec_clock_and_port_config_test.sv ----
`timescale 1ns/10ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin failures++; \
$display("BAD %0t got %h want %h", $time, g, e); end end
module codec_clock_and_port_config_test;
    import ccc_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWrData = 8'h00;
    logic regWrEn = 1'b0;
    logic regRdEn = 1'b0;
    logic pllUnlock = 1'b0;
    logic [7:0] regRdData;
    logic regRdValid, pllClk, oscClk, bitClk, frameClk, rmckOe, pllRefTrack;
    logic playBitClkOe, capBitClkOe, rjWordLen16, interpRolloffSlow;
    logic highpassHold, rateAutoDetectEn;
    logic extConvBitClk, capDataBitClk, rmckOut;
    logic [FRZ_COUNT*8-1:0] gainActive;
    int failures = 0;
    int checks_done = 0;
    int cycles = 0;
    always #5 core_clk = ~core_clk;
    ccc_far_end u_ccc_far_end (.core_clk(core_clk), .pllClk(pllClk),
        .oscClk(oscClk), .bitClk(bitClk), .frameClk(frameClk));
    ccc_top u_ccc_top (.core_clk(core_clk), .rst(rst), .clkEn(1'b1),
        .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
        .regRdEn(regRdEn), .regRdData(regRdData), .regRdValid(regRdValid),
        .pllClkIn(pllClk), .oscClkIn(oscClk), .pllUnlock(pllUnlock),
        .pllFreqCode(3'b010), .playBitClkIn(bitClk), .playBitClkOut(),
        .playBitClkOe(playBitClkOe), .playFrameIn(frameClk),
        .playFrameOut(), .playFrameOe(), .capBitClkIn(bitClk),
        .capBitClkOut(), .capBitClkOe(capBitClkOe), .capFrameIn(frameClk),
        .capFrameOut(), .capFrameOe(), .extConvBitClk(extConvBitClk),
        .capDataBitClk(capDataBitClk), .capDataFrame(), .rmckOut(rmckOut),
        .rmckOe(rmckOe),
        .pllRefTrack(pllRefTrack), .pllRefClk(), .rjWordLen16(rjWordLen16),
        .interpRolloffSlow(interpRolloffSlow), .highpassHold(highpassHold),
        .rateAutoDetectEn(rateAutoDetectEn), .gainActive(gainActive));
    task results;
        if (failures == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            results();
        end
    end
    task wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge core_clk);
        regAddr = a;
        regWrData = v;
        regWrEn = 1'b1;
        @(negedge core_clk);
        regWrEn = 1'b0;
    endtask
    task rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge core_clk);
        regAddr = a;
        regRdEn = 1'b1;
        @(negedge core_clk);
        regRdEn = 1'b0;
        `CHK(regRdValid, 1'b1)
        d = regRdData;
    endtask
    task settle;
        repeat (4) @(negedge core_clk);
    endtask
    task toggles(output int nr, output int ne, output int nd);
        logic pr, pe, pd;
        nr = 0;
        ne = 0;
        nd = 0;
        repeat (8) begin
            pr = rmckOut;
            pe = extConvBitClk;
            pd = capDataBitClk;
            @(negedge core_clk);
            nr += int'(rmckOut != pr);
            ne += int'(extConvBitClk != pe);
            nd += int'(capDataBitClk != pd);
        end
    endtask
    task t_reset;
        logic [7:0] d;
        rd(ADDR_MISC, d);
        `CHK(d, MISC_RST)
        `CHK({rmckOe, rateAutoDetectEn}, 2'b11)
    endtask
    task t_misc;
        logic [7:0] d;
        int nr, ne, nd;
        wr(ADDR_MISC, 8'hff);
        rd(ADDR_MISC, d);
        `CHK(d, MISC_MASK)
        `CHK(rmckOe, 1'b0)
        `CHK({interpRolloffSlow, highpassHold}, 2'b11)
        `CHK({playBitClkOe, capBitClkOe}, 2'b11)
        wr(ADDR_MISC, 8'h00);
        settle();
        `CHK({playBitClkOe, capBitClkOe, rmckOe}, 3'b001)
        wr(ADDR_MISC, 8'h81);
        settle();
        toggles(nr, ne, nd);
        `CHK(ne, 4)
        `CHK(nd, 4)
        wr(ADDR_FUNC, 8'h04);
        wr(ADDR_MISC, 8'h01);
        settle();
        toggles(nr, ne, nd);
        `CHK(ne, 1)
        `CHK(nd, 1)
        wr(ADDR_IFACE, 8'h01);
        settle();
        `CHK(rjWordLen16, 1'b1)
    endtask
    task t_freeze;
        wr(ADDR_MISC, 8'h10);
        wr(ADDR_FRZ_FIRST, 8'h5a);
        wr(ADDR_FRZ_LAST, 8'ha5);
        settle();
        `CHK(gainActive[15:0], 16'h0000)
        `CHK(gainActive[103:96], 8'h00)
        wr(ADDR_MISC, 8'h00);
        settle();
        `CHK({gainActive[103:96], gainActive[7:0]}, 16'ha55a)
    endtask
    task t_src;
        logic [7:0] d;
        int nr, ne, nd;
        wr(ADDR_CLK, 8'h30);
        rd(ADDR_CLK, d);
        `CHK(d, 8'h00)
        wr(ADDR_CLK, 8'h40);
        settle();
        toggles(nr, ne, nd);
        `CHK(nr, 2)
        pllUnlock = 1'b1;
        settle();
        toggles(nr, ne, nd);
        `CHK(nr, 4)
        pllUnlock = 1'b0;
        wr(ADDR_CLK, 8'h02);
        settle();
        rd(ADDR_STATUS, d);
        `CHK(d, 8'h0a)
        wr(ADDR_CLK, 8'h06);
        pllUnlock = 1'b1;
        settle();
        rd(ADDR_STATUS, d);
        `CHK(d[STAT_ACTIVE], 1'b1)
        pllUnlock = 1'b0;
        settle();
        rd(ADDR_STATUS, d);
        `CHK(d[STAT_ACTIVE], 1'b0)
        wr(ADDR_CLK, 8'h04);
        pllUnlock = 1'b1;
        settle();
        pllUnlock = 1'b0;
        settle();
        rd(ADDR_STATUS, d);
        `CHK(d[STAT_ACTIVE], 1'b1)
    endtask
    task t_force;
        logic [7:0] d;
        int nr, ne, nd;
        wr(ADDR_CLK, 8'h09);
        pllUnlock = 1'b1;
        settle();
        rd(ADDR_STATUS, d);
        `CHK(d[2:0], PLL_CODE_FORCED)
        `CHK({rateAutoDetectEn, pllRefTrack}, 2'b01)
        toggles(nr, ne, nd);
        `CHK(nr, 4)
        pllUnlock = 1'b0;
        wr(ADDR_MISC, 8'h01);
        settle();
        `CHK(pllRefTrack, 1'b0)
        wr(ADDR_CLK, 8'h00);
    endtask
    task t_ratio;
        logic [7:0] d;
        repeat (600) @(negedge core_clk);
        wr(ADDR_RATIO, 8'h11);
        rd(ADDR_RATIO, d);
        `CHK(d, 8'h80)
        rd(8'h0a, d);
        `CHK(d, 8'h00)
    endtask
    initial begin
        repeat (20) @(negedge core_clk);
        rst = 1'b0;
        t_reset();
        t_misc();
        t_freeze();
        t_src();
        t_force();
        t_ratio();
        results();
    end
endmodule
